// >>> src/otp_cfg_pkg.sv
/*
 * Constants, field layouts, decode functions and the decoded-settings
 * carrier for the one-time-programmable sensor configuration bank.
 * Assumes a 32-bit APB with a 12-bit byte address.
 */
package otp_cfg_pkg;

	// ----------------------------------------------------------------
	// register map
	// ----------------------------------------------------------------
	localparam int ADDR_W = 12;
	localparam int DATA_W = 32;
	localparam int NUM_BANKS = 3;
	localparam logic [7:0] BANK0_INDEX = 8'hc4;
	localparam logic [7:0] BANK1_INDEX = 8'hc5;
	localparam logic [7:0] BANK2_INDEX = 8'hc6;
	localparam logic [7:0] STATUS_INDEX = 8'hc7;
	localparam logic [ADDR_W-1:0] BANK0_ADDR = {2'h0, BANK0_INDEX, 2'h0};
	localparam logic [ADDR_W-1:0] BANK1_ADDR = {2'h0, BANK1_INDEX, 2'h0};
	localparam logic [ADDR_W-1:0] BANK2_ADDR = {2'h0, BANK2_INDEX, 2'h0};
	localparam logic [ADDR_W-1:0] STATUS_ADDR = {2'h0, STATUS_INDEX, 2'h0};

	// blank fuse value, also the reset value of every bank
	localparam logic [7:0] FUSE_BLANK = 8'h00;

	// ----------------------------------------------------------------
	// field positions
	// ----------------------------------------------------------------
	localparam int TOUCH_OUTPUT_FUNCTION_BIT = 7;
	localparam int PROXIMITY_OUTPUT_FUNCTION_BIT = 6;
	localparam int POL_BIT = 5;
	localparam int TOUCH_THRESHOLD_SELECT_LSB = 2;
	localparam int PROXIMITY_THRESHOLD_SELECT_LSB = 0;
	localparam int HALT_LSB = 6;
	localparam int BASE_LSB = 0;
	localparam int ATI_BIT = 2;
	localparam int ST_PROG_LSB = 0;
	localparam int ST_REFUSED_BIT = 3;
	localparam int ST_FULL_BIT = 4;
	localparam logic ATI_FULL = 1'b0;

	// ----------------------------------------------------------------
	// halt-time codes and times in seconds
	// ----------------------------------------------------------------
	localparam logic [1:0] HALT_20S = 2'h0;
	localparam logic [1:0] HALT_40S = 2'h1;
	localparam logic [1:0] HALT_NEVER = 2'h2;
	localparam logic [1:0] HALT_ALWAYS = 2'h3;
	localparam logic [5:0] HALT_SHORT_S = 6'h14;
	localparam logic [5:0] HALT_LONG_S = 6'h28;
	localparam logic [5:0] PROX_HOLD_S = 6'h28;
	localparam logic [5:0] HALT_NONE_S = 6'h00;

	typedef struct packed {
		logic touch_output_function;
		logic proximity_output_function;
		logic outputs_active_high;
		logic [7:0] touch_threshold_num;
		logic [4:0] proximity_threshold;
		logic [1:0] halt_time_select;
		logic [5:0] halt_seconds;
		logic halt_never;
		logic halt_always;
		logic proximity_hold_40s;
		logic [8:0] base_value;
		logic full_tuning;
	} sensor_config_t;

	// ----------------------------------------------------------------
	// decode functions
	// ----------------------------------------------------------------
	function automatic logic [7:0] touch_threshold_num(input logic [2:0] code);
		case (code)
			3'h0: return 8'h48;
			3'h1: return 8'h08;
			3'h2: return 8'h18;
			3'h3: return 8'h30;
			3'h4: return 8'h60;
			3'h5: return 8'h80;
			3'h6: return 8'ha0;
			default: return 8'hc0;
		endcase
	endfunction : touch_threshold_num

	function automatic logic [4:0] proximity_threshold(input logic [1:0] code);
		case (code)
			2'h0: return 5'h04;
			2'h1: return 5'h02;
			2'h2: return 5'h08;
			default: return 5'h10;
		endcase
	endfunction : proximity_threshold

	function automatic logic [8:0] base_value(input logic [2:0] code);
		case (code)
			3'h0: return 9'h0c8;
			3'h1: return 9'h032;
			3'h2: return 9'h04b;
			3'h3: return 9'h064;
			3'h4: return 9'h096;
			3'h5: return 9'h0fa;
			3'h6: return 9'h12c;
			default: return 9'h1f4;
		endcase
	endfunction : base_value

	function automatic logic [5:0] halt_seconds(input logic [1:0] code);
		case (code)
			HALT_20S: return HALT_SHORT_S;
			HALT_40S: return HALT_LONG_S;
			HALT_NEVER: return HALT_NONE_S;
			default: return PROX_HOLD_S;
		endcase
	endfunction : halt_seconds

	function automatic logic full_tuning(input logic [7:0] b2);
		return b2[ATI_BIT] == ATI_FULL;
	endfunction : full_tuning

	function automatic sensor_config_t decode_config(input logic [7:0] b0,
		input logic [7:0] b1, input logic [7:0] b2);
		sensor_config_t c;
		logic [7:0] hb;
		logic [1:0] hs;
		// halt/base layout only holds under full tuning
		hb = full_tuning(b2) ? b1 : FUSE_BLANK;
		hs = hb[HALT_LSB +: 2];
		c.touch_output_function = b0[TOUCH_OUTPUT_FUNCTION_BIT];
		c.proximity_output_function = b0[PROXIMITY_OUTPUT_FUNCTION_BIT];
		c.outputs_active_high = b0[POL_BIT];
		c.touch_threshold_num = touch_threshold_num(b0[TOUCH_THRESHOLD_SELECT_LSB +: 3]);
		c.proximity_threshold = proximity_threshold(b0[PROXIMITY_THRESHOLD_SELECT_LSB +: 2]);
		c.halt_time_select = hs;
		c.halt_seconds = halt_seconds(hs);
		c.halt_never = hs == HALT_NEVER;
		c.halt_always = hs == HALT_ALWAYS;
		c.proximity_hold_40s = hs == HALT_ALWAYS;
		c.base_value = base_value(hb[BASE_LSB +: 3]);
		c.full_tuning = full_tuning(b2);
		return c;
	endfunction : decode_config

endpackage : otp_cfg_pkg

// >>> src/otp_fuse_byte.sv
/*
 * One write-once configuration byte: blank until its first program
 * strobe, frozen afterwards until presetn clears it back to blank.
 * Assumes the strobe is a one-cycle pulse in the pclk domain.
 */
`timescale 1ns/1ns
`default_nettype none

module otp_fuse_byte
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic program_strobe,
	input wire logic [7:0] program_data,
	output logic [7:0] value,
	output logic programmed,
	output logic refused
);
	import otp_cfg_pkg::*;

	// later strobes bounce off a blown fuse
	assign refused = program_strobe & programmed;

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			value <= FUSE_BLANK;
			programmed <= 1'b0;
		end
		else if (program_strobe && !programmed)
		begin
			value <= program_data;
			programmed <= 1'b1;
		end
	end

endmodule : otp_fuse_byte

`default_nettype wire

// >>> src/otp_sensor_config_bank.sv
/*
 * APB register bank holding the write-once sensor configuration bytes
 * and driving the decoded settings to the sensing logic.
 * Assumes an APB master in the pclk domain and a program_enable level
 * that is already synchronous to pclk.
 */
// Local design decision: register access over APB.
`timescale 1ns/1ns
`default_nettype none

// Functional notes
// - each configuration byte can be written once after reset; later writes are ignored
// - unprogrammed banks read blank and give full default behaviour
// - under full tuning, bank one decodes as halt time and base value
// - programming works loose or in-circuit, gated by program_enable
// - every bank is one byte, read in the low bits of a word
// - first bank sits at index c4 with functions, polarity, thresholds
module otp_sensor_config_bank
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [otp_cfg_pkg::ADDR_W-1:0] paddr,
	input wire logic [otp_cfg_pkg::DATA_W-1:0] pwdata,
	input wire logic [3:0] pstrb,
	input wire logic program_enable,
	output logic [otp_cfg_pkg::DATA_W-1:0] prdata,
	output logic pready,
	output logic pslverr,
	output otp_cfg_pkg::sensor_config_t sensor_config
);
	import otp_cfg_pkg::*;

	// shipped defaults, the decode of three blank bytes
	localparam sensor_config_t BLANK_CONFIG = decode_config(FUSE_BLANK,
		FUSE_BLANK, FUSE_BLANK);

	// ----------------------------------------------------------------
	// bus decode
	// ----------------------------------------------------------------
	logic [7:0] bank_value [NUM_BANKS];
	logic [NUM_BANKS-1:0] bank_programmed;
	logic [NUM_BANKS-1:0] bank_refused;
	logic [NUM_BANKS-1:0] hit_bank;
	logic [NUM_BANKS-1:0] fuse_strobe;
	logic refused_flag;
	logic [DATA_W-1:0] rd_data;
	sensor_config_t next_sensor_config;

	wire access_wait = psel & penable & ~pready;
	wire access_done = psel & penable & pready;
	wire hit_status = paddr == STATUS_ADDR;
	wire hit_any_bank = |hit_bank;
	wire mapped = hit_any_bank | hit_status;
	wire low_lane = pstrb[0];
	wire hit_blown = |(hit_bank & bank_programmed);

	assign hit_bank[0] = paddr == BANK0_ADDR;
	assign hit_bank[1] = paddr == BANK1_ADDR;
	assign hit_bank[2] = paddr == BANK2_ADDR;

	// a bank write needs the pin path open and a blank fuse
	wire bank_write_err = pwrite & hit_any_bank
		& (~program_enable | hit_blown);
	wire next_err = ~mapped | bank_write_err;

	// ----------------------------------------------------------------
	// fuse bytes
	// ----------------------------------------------------------------
	genvar gi;
	generate
		for (gi = 0; gi < NUM_BANKS; gi++)
		begin : g_bank
			assign fuse_strobe[gi] = access_done & pwrite & low_lane
				& hit_bank[gi] & program_enable;
			otp_fuse_byte u_fuse
			(
				.pclk(pclk),
				.presetn(presetn),
				.program_strobe(fuse_strobe[gi]),
				.program_data(pwdata[7:0]),
				.value(bank_value[gi]),
				.programmed(bank_programmed[gi]),
				.refused(bank_refused[gi])
			);
		end
	endgenerate

	// ----------------------------------------------------------------
	// status
	// ----------------------------------------------------------------
	wire refused_event = (|bank_refused) | (access_done & pwrite
		& low_lane & hit_any_bank & ~program_enable);
	wire refused_clear = access_done & pwrite & hit_status & low_lane
		& pwdata[ST_REFUSED_BIT];
	// a new refusal beats a clear in the same cycle
	wire next_refused_flag = refused_event
		| (refused_flag & ~refused_clear);

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			refused_flag <= 1'b0;
		else
			refused_flag <= next_refused_flag;
	end

	// ----------------------------------------------------------------
	// read mux
	// ----------------------------------------------------------------
	wire [DATA_W-1:0] status_word = {27'h0, full_tuning(bank_value[2]),
		refused_flag, bank_programmed};
	assign rd_data = hit_bank[0] ? {24'h0, bank_value[0]} :
		hit_bank[1] ? {24'h0, bank_value[1]} :
		hit_bank[2] ? {24'h0, bank_value[2]} :
		hit_status ? status_word : 32'h0;

	// ----------------------------------------------------------------
	// apb answer: one wait cycle, then pready with data
	// ----------------------------------------------------------------
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			pready <= 1'b0;
			pslverr <= 1'b0;
			prdata <= 32'h0;
		end
		else
		begin
			pready <= access_wait;
			pslverr <= access_wait & next_err;
			if (access_wait && !pwrite)
				prdata <= rd_data;
		end
	end

	// ----------------------------------------------------------------
	// decoded settings
	// ----------------------------------------------------------------
	// blank bytes decode to the shipped defaults
	assign next_sensor_config = decode_config(bank_value[0],
		bank_value[1], bank_value[2]);

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			sensor_config <= BLANK_CONFIG;
		else
			sensor_config <= next_sensor_config;
	end

	// ----------------------------------------------------------------
	// checks
	// ----------------------------------------------------------------
	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);

	sequence s_wr_bank0_done;
		access_done && pwrite && low_lane && hit_bank[0];
	endsequence

	sequence s_rd_bank0_wait;
		access_wait && !pwrite && hit_bank[0];
	endsequence

	sequence s_bank0_steady;
		$stable(bank_value[0]) [*2];
	endsequence

	property p_write_once;
		bank_programmed[0] ##0 s_wr_bank0_done
			|=> $stable(bank_value[0]) && refused_flag;
	endproperty
	a_write_once: assert property (p_write_once)
		else $error("programmed bank changed on a second write");

	property p_blown_stays;
		bank_programmed[1] |=> bank_programmed[1] [*3];
	endproperty
	a_blown_stays: assert property (p_blown_stays)
		else $error("programmed flag fell");

	property p_blank_default;
		(bank_programmed == 3'h0) [*2]
			|-> sensor_config.touch_threshold_num == 8'h48
			&& sensor_config.proximity_threshold == 5'h04
			&& sensor_config.base_value == 9'h0c8
			&& sensor_config.full_tuning
			&& !sensor_config.outputs_active_high;
	endproperty
	a_blank_default: assert property (p_blank_default)
		else $error("blank banks do not give defaults");

	property p_full_tuning_layout;
		(!bank_value[2][ATI_BIT] && $stable(bank_value[1])) [*2]
			|-> sensor_config.base_value == base_value(bank_value[1][2:0])
			&& sensor_config.halt_time_select == bank_value[1][7:6];
	endproperty
	a_full_tuning_layout: assert property (p_full_tuning_layout)
		else $error("bank one not decoded as halt and base");

	property p_partial_tuning_default;
		(bank_value[2][ATI_BIT] && $stable(bank_value[1])) [*2]
			|-> sensor_config.base_value == 9'h0c8
			&& !sensor_config.full_tuning;
	endproperty
	a_partial_tuning_default: assert property (p_partial_tuning_default)
		else $error("halt and base decoded outside full tuning");

	property p_pin_gate;
		access_done && pwrite && hit_any_bank && !program_enable
			&& low_lane |=> $stable(bank_programmed) ##0 refused_flag;
	endproperty
	a_pin_gate: assert property (p_pin_gate)
		else $error("bank programmed with programming path closed");

	property p_byte_read;
		s_rd_bank0_wait |=> pready && prdata[31:8] == 24'h0
			&& prdata[7:0] == bank_value[0];
	endproperty
	a_byte_read: assert property (p_byte_read)
		else $error("bank read not one byte in low lane");

	property p_bank0_program;
		!bank_programmed[0] && program_enable ##0 s_wr_bank0_done
			|=> bank_programmed[0]
			&& bank_value[0] == $past(pwdata[7:0]);
	endproperty
	a_bank0_program: assert property (p_bank0_program)
		else $error("write at first bank index did not program it");

	property p_halt_always;
		(!bank_value[2][ATI_BIT] && bank_value[1][7:6] == HALT_ALWAYS
			&& $stable(bank_value[1])) [*2]
			|-> sensor_config.halt_always
			&& sensor_config.proximity_hold_40s
			&& sensor_config.halt_seconds == 6'h28;
	endproperty
	a_halt_always: assert property (p_halt_always)
		else $error("halt code 11 not decoded as always");

	property p_bank0_fields;
		s_bank0_steady |-> sensor_config.touch_output_function
			== bank_value[0][7]
			&& sensor_config.proximity_output_function == bank_value[0][6]
			&& sensor_config.outputs_active_high == bank_value[0][5]
			&& sensor_config.touch_threshold_num
			== touch_threshold_num(bank_value[0][4:2])
			&& sensor_config.proximity_threshold
			== proximity_threshold(bank_value[0][1:0]);
	endproperty
	a_bank0_fields: assert property (p_bank0_fields)
		else $error("first bank fields decoded wrongly");

	property p_one_wait;
		access_wait |=> pready ##1 !pready;
	endproperty
	a_one_wait: assert property (p_one_wait)
		else $error("apb answer not after exactly one wait cycle");

	property p_unmapped_err;
		access_wait && !mapped |=> pready && pslverr && prdata == 32'h0;
	endproperty
	a_unmapped_err: assert property (p_unmapped_err)
		else $error("unmapped access not answered with error");

	// ----------------------------------------------------------------
	// status and strobe checks
	// ----------------------------------------------------------------
	sequence s_status_clear;
		access_done && pwrite && hit_status && low_lane
			&& pwdata[ST_REFUSED_BIT];
	endsequence

	property p_refused_clear;
		s_status_clear ##0 !refused_event |=> !refused_flag;
	endproperty
	a_refused_clear: assert property (p_refused_clear)
		else $error("refused flag not cleared by status write");

	property p_refusal_wins;
		refused_event |=> refused_flag;
	endproperty
	a_refusal_wins: assert property (p_refusal_wins)
		else $error("refusal lost against a clear");

	property p_masked_write;
		access_done && pwrite && hit_any_bank && !low_lane
			|=> $stable(bank_programmed) && $stable(bank_value[0])
			&& $stable(bank_value[1]) && $stable(bank_value[2]);
	endproperty
	a_masked_write: assert property (p_masked_write)
		else $error("write without low strobe changed a bank");

	property p_status_read;
		access_wait && !pwrite && hit_status
			|=> pready && prdata[2:0] == $past(bank_programmed)
			&& prdata[ST_REFUSED_BIT] == $past(refused_flag)
			&& prdata[31:5] == 27'h0;
	endproperty
	a_status_read: assert property (p_status_read)
		else $error("status word does not show fuse state");

endmodule : otp_sensor_config_bank

`default_nettype wire

// >>> tb/fuse_programmer.sv
/*
 * Behavioural programming tool: an APB master that writes and reads
 * the configuration fuses of the sensor bank.
 * Assumes a free-running pclk and a slave that answers with pready.
 */
`timescale 1ns/1ns
`default_nettype none

module fuse_programmer
(
	input wire logic pclk,
	output var logic psel,
	output var logic penable,
	output var logic pwrite,
	output var logic [otp_cfg_pkg::ADDR_W-1:0] paddr,
	output var logic [otp_cfg_pkg::DATA_W-1:0] pwdata,
	output var logic [3:0] pstrb,
	input wire logic pready,
	input wire logic pslverr,
	input wire logic [otp_cfg_pkg::DATA_W-1:0] prdata
);
	import otp_cfg_pkg::*;

	initial
	begin
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = '0;
		pwdata = '0;
		pstrb = 4'hf;
	end

	// ----------------------------------------------------------------
	// one transfer, the same whether loose or in-circuit
	// ----------------------------------------------------------------
	task automatic xfer(input logic wr, input logic [ADDR_W-1:0] a,
		input logic [DATA_W-1:0] d, input logic [3:0] s,
		output logic [DATA_W-1:0] rd, output logic err);
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		pstrb <= s;
		@(posedge pclk);
		penable <= 1'b1;
		do
			@(posedge pclk);
		while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		// released address and data lines must not keep their last value
		paddr <= ~a;
		pwdata <= ~d;
	endtask : xfer
endmodule : fuse_programmer

`default_nettype wire

// >>> tb/test_otp_sensor_config_bank.sv
/*
 * Self-checking bench for the write-once sensor configuration bank.
 * Assumes the design and fuse_programmer are compiled before it.
 */
`timescale 1ns/1ns
`default_nettype none

module test_otp_sensor_config_bank;
	import otp_cfg_pkg::*;

	logic pclk;
	logic presetn;
	logic psel;
	logic penable;
	logic pwrite;
	logic [ADDR_W-1:0] paddr;
	logic [DATA_W-1:0] pwdata;
	logic [3:0] pstrb;
	logic program_enable;
	logic [DATA_W-1:0] prdata;
	logic pready;
	logic pslverr;
	sensor_config_t cfg;
	int errors = 0;
	int checked = 0;

	otp_sensor_config_bank dut_u (.pclk(pclk), .presetn(presetn),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .pstrb(pstrb), .program_enable(program_enable),
		.prdata(prdata), .pready(pready), .pslverr(pslverr),
		.sensor_config(cfg));

	fuse_programmer tool_u (.pclk(pclk), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
		.pready(pready), .pslverr(pslverr), .prdata(prdata));

	// ----------------------------------------------------------------
	// helpers
	// ----------------------------------------------------------------
	task automatic chk(input string what, input logic [31:0] exp,
		input logic [31:0] got);
		checked++;
		if (got !== exp)
		begin
			errors++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, got);
		end
	endtask : chk

	task automatic op(input logic wr, input logic [ADDR_W-1:0] a,
		input logic [31:0] d, input logic [31:0] exp, input logic experr);
		logic [31:0] rd;
		logic err;
		tool_u.xfer(wr, a, d, 4'hf, rd, err);
		chk("pslverr", {31'h0, experr}, {31'h0, err});
		if (!wr)
			chk("prdata", exp, rd);
	endtask : op

	task automatic settle();
		repeat (3) @(posedge pclk);
	endtask : settle

	task automatic end_sim();
		$display("comparisons %0d mismatches %0d", checked, errors);
		if (errors == 0 && checked > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask : end_sim

	// ----------------------------------------------------------------
	// scenarios
	// ----------------------------------------------------------------
	task automatic t_defaults();
		op(1'b0, BANK0_ADDR, 0, 32'h0, 1'b0);
		op(1'b0, BANK1_ADDR, 0, 32'h0, 1'b0);
		op(1'b0, STATUS_ADDR, 0, 32'h10, 1'b0);
		chk("touch thr", 32'h48, 32'(cfg.touch_threshold_num));
		chk("prox thr", 32'h04, 32'(cfg.proximity_threshold));
		chk("base", 32'h0c8, 32'(cfg.base_value));
		chk("halt s", 32'h14, 32'(cfg.halt_seconds));
		chk("full", 32'h1, 32'(cfg.full_tuning));
	endtask : t_defaults

	task automatic t_closed();
		program_enable <= 1'b0;
		op(1'b1, BANK0_ADDR, 32'hff, 0, 1'b1);
		op(1'b0, BANK0_ADDR, 0, 32'h0, 1'b0);
		op(1'b0, STATUS_ADDR, 0, 32'h18, 1'b0);
		program_enable <= 1'b1;
	endtask : t_closed

	task automatic t_bank0();
		op(1'b1, BANK0_ADDR, 32'hffff_ffb6, 0, 1'b0);
		settle();
		op(1'b0, BANK0_ADDR, 0, 32'hb6, 1'b0);
		chk("toggle", 32'h1, 32'(cfg.touch_output_function));
		chk("latch", 32'h0, 32'(cfg.proximity_output_function));
		chk("high", 32'h1, 32'(cfg.outputs_active_high));
		chk("touch thr", 32'h80, 32'(cfg.touch_threshold_num));
		chk("prox thr", 32'h08, 32'(cfg.proximity_threshold));
		op(1'b1, BANK0_ADDR, 32'h49, 0, 1'b1);
		op(1'b0, BANK0_ADDR, 0, 32'hb6, 1'b0);
	endtask : t_bank0

	task automatic t_halt();
		op(1'b1, BANK1_ADDR, 32'hc7, 0, 1'b0);
		settle();
		chk("always", 32'h1, 32'(cfg.halt_always));
		chk("hold 40", 32'h1, 32'(cfg.proximity_hold_40s));
		chk("never", 32'h0, 32'(cfg.halt_never));
		chk("halt s", 32'h28, 32'(cfg.halt_seconds));
		chk("halt sel", 32'h3, 32'(cfg.halt_time_select));
		chk("base", 32'h1f4, 32'(cfg.base_value));
		op(1'b1, BANK2_ADDR, 32'h04, 0, 1'b0);
		settle();
		chk("full", 32'h0, 32'(cfg.full_tuning));
		chk("base", 32'h0c8, 32'(cfg.base_value));
		chk("always", 32'h0, 32'(cfg.halt_always));
		chk("halt s", 32'h14, 32'(cfg.halt_seconds));
		op(1'b0, STATUS_ADDR, 0, 32'h0f, 1'b0);
	endtask : t_halt

	task automatic t_status();
		logic [31:0] rd;
		logic err;
		op(1'b1, STATUS_ADDR, 32'h08, 0, 1'b0);
		op(1'b0, STATUS_ADDR, 0, 32'h07, 1'b0);
		tool_u.xfer(1'b1, BANK0_ADDR, 32'h11, 4'he, rd, err);
		chk("masked err", 32'h1, {31'h0, err});
		op(1'b0, STATUS_ADDR, 0, 32'h07, 1'b0);
		op(1'b0, BANK0_ADDR, 0, 32'hb6, 1'b0);
	endtask : t_status

	task automatic t_reset();
		presetn <= 1'b0;
		repeat (2) @(posedge pclk);
		presetn <= 1'b1;
		op(1'b0, STATUS_ADDR, 0, 32'h10, 1'b0);
		chk("base", 32'h0c8, 32'(cfg.base_value));
		op(1'b1, BANK1_ADDR, 32'h80, 0, 1'b0);
		settle();
		chk("never", 32'h1, 32'(cfg.halt_never));
		chk("halt s", 32'h0, 32'(cfg.halt_seconds));
		chk("always", 32'h0, 32'(cfg.halt_always));
		chk("halt sel", 32'h2, 32'(cfg.halt_time_select));
	endtask : t_reset

	task automatic t_unmapped();
		op(1'b0, 12'h400, 0, 32'h0, 1'b1);
		op(1'b1, 12'h320, 32'h5a, 0, 1'b1);
	endtask : t_unmapped

	// ----------------------------------------------------------------
	// clock, reset, sequence, watchdog
	// ----------------------------------------------------------------
	initial
	begin
		pclk = 1'b0;
		forever
			#4 pclk = ~pclk;
	end

	initial
	begin
		presetn = 1'b0;
		program_enable = 1'b1;
		repeat (16) @(posedge pclk);
		presetn <= 1'b1;
		t_defaults();
		t_closed();
		t_bank0();
		t_halt();
		t_unmapped();
		t_status();
		t_reset();
		end_sim();
	end

	initial
	begin
		repeat (3000) @(posedge pclk);
		errors++;
		end_sim();
	end
endmodule : test_otp_sensor_config_bank

`default_nettype wire
